/* File: bench/rcmb_far_end.sv */
`timescale 1ns/1ps
module rcmb_far_end (
    // Management bus
    input wire logic mgmt_rx_clock_i,
    input wire logic mgmt_rx_clock_oe_i,
    input wire logic mgmt_rx_serial_i,
    // Bench command
    input wire logic want_compress_i,
    // Far side drive
    output logic compress_request_n_o,
    output logic far_clk_o,
    output logic far_data_o,
    output logic far_frame_o
);
    logic got[$];

    // Low asks for compression
    assign compress_request_n_o = !want_compress_i;

    // Sample on clock rise
    always @(posedge mgmt_rx_clock_i) begin
        if (mgmt_rx_clock_oe_i === 1'b1) begin
            got.push_back(mgmt_rx_serial_i);
        end
    end

    // Idle levels
    initial begin
        far_clk_o = 1'b0;
        far_data_o = 1'b0;
        far_frame_o = 1'b0;
    end

    // Other repeater sends one frame
    task automatic send(input logic [7:0] b);
        for (int k = 7; k >= 0; k--) begin
            far_frame_o = 1'b1;
            far_data_o = b[k];
            #80 far_clk_o = 1'b1;
            #80 far_clk_o = 1'b0;
        end
        #80 far_frame_o = 1'b0;
        far_data_o = !b[0];
    endtask
endmodule

/* File: bench/rcmb_pins_chk.sv */
`timescale 1ns/1ps
module rcmb_pins_chk (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Core inputs
    input wire logic seg_rx_active_i,
    input wire logic seg_rx_collision_i,
    input wire logic [rcmb_pkg::PORT_COUNT-1:0] port_collision_i,
    input wire logic tx_collision_i,
    input wire logic seg_manchester_i,
    input wire logic activity_sense_i,
    // Cascade outputs
    input wire logic packet_bus_drive_enable_o,
    input wire logic cascade_serial_data_o,
    input wire logic cascade_serial_data_oe_o,
    input wire logic cascade_frame_enable_oe_o,
    input wire logic cascade_serial_clock_o,
    input wire logic cascade_serial_clock_oe_o,
    input wire logic receive_port_collision_oe_o,
    // Status outputs
    input wire logic local_activity_drive_o,
    input wire logic local_activity_drive_oe_o,
    input wire logic multi_collision_drive_oe_o,
    input wire logic activity_seen_o,
    input wire logic manchester_rx_monitor_o,
    // Management outputs
    input wire logic mgmt_rx_clock_o,
    input wire logic mgmt_rx_clock_oe_o,
    input wire logic mgmt_rx_serial_o,
    input wire logic mgmt_rx_serial_oe_o,
    input wire logic mgmt_carrier_sense_o,
    input wire logic mgmt_carrier_sense_oe_o,
    input wire logic mgmt_drive_enable_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    ////////////////////////////////////////////////////////////////////////////
    // Cascade side
    a_pkt_enable_match: assert property (
        packet_bus_drive_enable_o == (cascade_serial_data_oe_o && cascade_frame_enable_oe_o
            && cascade_serial_clock_oe_o && receive_port_collision_oe_o))
        else $error("pkt enable wrong");
    a_frame_start: assert property (
        seg_rx_active_i && !mgmt_drive_enable_o |=> packet_bus_drive_enable_o && mgmt_drive_enable_o)
        else $error("frame start late");
    a_casc_data_fall: assert property (
        $changed(cascade_serial_data_o) && cascade_serial_data_oe_o && $past(cascade_serial_data_oe_o)
        |-> !cascade_serial_clock_o)
        else $error("cascade data early");

    ////////////////////////////////////////////////////////////////////////////
    // Management side
    a_mgmt_data_fall: assert property (
        $changed(mgmt_rx_serial_o) && mgmt_rx_serial_oe_o && $past(mgmt_rx_serial_oe_o) |-> !mgmt_rx_clock_o)
        else $error("mgmt data early");
    a_mgmt_clk_high: assert property (
        $rose(mgmt_rx_clock_o) |-> mgmt_rx_clock_oe_o ##11 mgmt_rx_clock_o ##1 !mgmt_rx_clock_o)
        else $error("mgmt clock wrong");
    a_mgmt_enables: assert property (
        mgmt_drive_enable_o == mgmt_rx_clock_oe_o && mgmt_rx_clock_oe_o == mgmt_rx_serial_oe_o
        && mgmt_rx_serial_oe_o == mgmt_carrier_sense_oe_o)
        else $error("management enables disagree");
    a_crs_framing: assert property (
        mgmt_carrier_sense_oe_o |-> mgmt_carrier_sense_o)
        else $error("carrier low");

    ////////////////////////////////////////////////////////////////////////////
    // Drives and sense
    a_act_drive: assert property (
        !local_activity_drive_o && local_activity_drive_oe_o == $past(seg_rx_active_i || seg_rx_collision_i))
        else $error("activity drive wrong");
    a_mcol_drive: assert property (
        multi_collision_drive_oe_o == $past(tx_collision_i || ($countones(port_collision_i) > 1)))
        else $error("mcol drive wrong");
    a_act_sense_lag: assert property (
        $past(rst_n_i, 4) |-> activity_seen_o == $past(!activity_sense_i, 3))
        else $error("act sense wrong");
    a_monitor_copy: assert property (
        manchester_rx_monitor_o == $past(seg_manchester_i))
        else $error("monitor wrong");
endmodule

/* File: bench/test_rcmb_pins.sv */
`timescale 1ns/1ps
module test_rcmb_pins;
    import rcmb_pkg::*;
    logic clk_sys_i, rst_n_i, seg_rx_active_i, seg_rx_collision_i, tx_collision_i, seg_rx_bit_i;
    logic seg_manchester_i, seg_bit_req_o, activity_seen_o, multi_collision_seen_o, cascade_rx_bit_o;
    logic [PORT_COUNT-1:0] port_collision_i;
    logic [STATUS_BITS-1:0] status_word_i;
    logic cascade_rx_strobe_o, cascade_rx_frame_o, cascade_rx_collision_o, mgmt_bus_busy_o, compress_active_o;
    logic cascade_serial_data_i, cascade_serial_data_o, cascade_serial_data_oe_o, cascade_frame_enable_i;
    logic cascade_frame_enable_o, cascade_frame_enable_oe_o, cascade_serial_clock_i, cascade_serial_clock_o;
    logic cascade_serial_clock_oe_o, receive_port_collision_i, receive_port_collision_o;
    logic receive_port_collision_oe_o, packet_bus_drive_enable_o, local_activity_drive_o;
    logic local_activity_drive_oe_o, activity_sense_i, multi_collision_drive_o, multi_collision_drive_oe_o;
    logic multi_collision_sense_i, mgmt_rx_clock_o, mgmt_rx_clock_oe_o, mgmt_rx_serial_o, mgmt_rx_serial_oe_o;
    logic mgmt_carrier_sense_i, mgmt_carrier_sense_o, mgmt_carrier_sense_oe_o, mgmt_drive_enable_o;
    logic compress_request_n_i, manchester_rx_monitor_o;
    logic other_act, other_col, other_crs, want_compress, far_clk, far_data, far_frame, comp_seen, frame_seen;
    logic [7:0] rx_byte;
    int failures = 0, comparisons = 0, cycles = 0, bit_idx, pkt_len, strobes;
    // Row: inputs [24:6], expected flags [5:0]
    localparam logic [24:0] ROWS [0:6] = '{
        25'h0000000, 25'h1000869, 25'h180083C, 25'h0000414, 25'h0000208, 25'h0000104, 25'h00000C3
    };

    ////////////////////////////////////////////////////////////////////////////
    // Shared lines
    assign activity_sense_i = !(local_activity_drive_oe_o || other_act);
    assign multi_collision_sense_i = !(multi_collision_drive_oe_o || other_col);
    assign cascade_serial_data_i = cascade_serial_data_oe_o ? cascade_serial_data_o : far_data;
    assign cascade_frame_enable_i = cascade_frame_enable_oe_o ? cascade_frame_enable_o : far_frame;
    assign cascade_serial_clock_i = cascade_serial_clock_oe_o ? cascade_serial_clock_o : far_clk;
    assign receive_port_collision_i = receive_port_collision_oe_o ? receive_port_collision_o : 1'b0;
    assign mgmt_carrier_sense_i = mgmt_carrier_sense_oe_o ? mgmt_carrier_sense_o : other_crs;

    rcmb_pins rcmb_pins_i (.*);
    rcmb_far_end rcmb_far_end_i (.mgmt_rx_clock_i(mgmt_rx_clock_o), .mgmt_rx_clock_oe_i(mgmt_rx_clock_oe_o),
        .mgmt_rx_serial_i(mgmt_rx_serial_o), .want_compress_i(want_compress),
        .compress_request_n_o(compress_request_n_i), .far_clk_o(far_clk), .far_data_o(far_data),
        .far_frame_o(far_frame));

    // Clock and hang guard
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            give_verdict();
        end
    end

    function automatic logic pbit(input int i);
        return i[0] ^ i[2];
    endfunction

    task automatic check(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Core model and flag watch
    always @(negedge clk_sys_i) begin
        if (seg_bit_req_o === 1'b1) begin
            bit_idx++;
            if (bit_idx >= pkt_len) seg_rx_active_i = 1'b0;
            else seg_rx_bit_i = pbit(bit_idx);
        end
        if (compress_active_o === 1'b1) comp_seen = 1'b1;
        if (cascade_rx_frame_o === 1'b1) frame_seen = 1'b1;
        if (cascade_rx_strobe_o === 1'b1) begin
            rx_byte = {rx_byte[6:0], cascade_rx_bit_o};
            strobes++;
        end
    end

    // One packet, then the stream bit by bit
    task automatic run_packet(input int n, input logic cmp, input int nexp);
        int w = 0;
        rcmb_far_end_i.got.delete();
        pkt_len = n;
        bit_idx = 0;
        comp_seen = 1'b0;
        want_compress = cmp;
        seg_rx_bit_i = pbit(0);
        seg_rx_active_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        while (mgmt_drive_enable_o === 1'b1 && w < n * 30 + 1000) begin
            @(negedge clk_sys_i);
            w++;
        end
        check(rcmb_far_end_i.got.size(), nexp);
        for (int k = 0; k < nexp; k++) begin
            check(rcmb_far_end_i.got[k], k < nexp - 16 ? pbit(k) : status_word_i[nexp - 1 - k]);
        end
        check(comp_seen, cmp);
    endtask

    // Main sequence
    initial begin
        rst_n_i = 1'b0;
        {seg_rx_active_i, seg_rx_collision_i, tx_collision_i, seg_rx_bit_i, seg_manchester_i} = '0;
        {other_act, other_col, other_crs, want_compress} = '0;
        port_collision_i = '0;
        status_word_i = 16'hC35A;
        repeat (12) @(negedge clk_sys_i);
        check({packet_bus_drive_enable_o, mgmt_drive_enable_o, mgmt_rx_clock_o, local_activity_drive_oe_o}, 0);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        foreach (ROWS[r]) begin
            {seg_rx_collision_i, port_collision_i, tx_collision_i, other_act, other_col, other_crs,
                seg_manchester_i} = ROWS[r][24:6];
            repeat (5) @(negedge clk_sys_i);
            check({local_activity_drive_oe_o, multi_collision_drive_oe_o, activity_seen_o,
                multi_collision_seen_o, mgmt_bus_busy_o, manchester_rx_monitor_o}, ROWS[r][5:0]);
        end
        other_crs = 1'b0;
        repeat (5) @(negedge clk_sys_i);
        run_packet(10, 1'b0, 26);
        run_packet(20, 1'b1, 36);
        run_packet(520, 1'b1, 528);
        run_packet(520, 1'b0, 536);
        #1.3;
        rcmb_far_end_i.send(8'hB4);
        repeat (10) @(negedge clk_sys_i);
        check(strobes, 8);
        check(rx_byte, 8'hB4);
        check(frame_seen, 1);
        give_verdict();
    end
endmodule

bind rcmb_pins rcmb_pins_chk rcmb_pins_chk_i (.*);

/* File: rtl/rcmb_pins.sv */
`timescale 1ns/1ps
// Functional notes
// [R01] Packet bus drive enable high while cascade data, frame, clock, collision driven.
// [R02] Drive enable low means the transceiver receives from the shared bus.
// [R03] System supplies the reference clock that times all logic.
// [R04] Open-drain activity drive asserted while receiving data or collision locally.
// [R05] Activity sense shows this or any cascaded repeater receiving.
// [R06] Multi-collision drive on transmit collision or several port collisions.
// [R07] Multi-collision sense shows such a collision anywhere in the cascade.
// [R08] Management serial data changes only on management clock falling edge.
// [R09] Management clock toggles only while receiving a packet, else idle.
// [R10] Management carrier sense driven as framing while receiving, input otherwise.
// [R11] Management data is NRZ packet then status, only while receiving.
// [R12] Management drive enable high while management outputs go onto the bus.
// [R13] Compress request low while carrier active compresses the current packet.
// [R14] Request tied low compresses every packet; tied high never compresses.
// [R15] Manchester data of the receiving port appears on the test output.
// [R16] Cascade data changes on clock fall; receiver samples on clock rise.
// [R17] Management clock and data released when this device is not the source.
module rcmb_pins (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Repeater core side
    input wire logic seg_rx_active_i,
    input wire logic seg_rx_collision_i,
    input wire logic [rcmb_pkg::PORT_COUNT-1:0] port_collision_i,
    input wire logic tx_collision_i,
    input wire logic seg_rx_bit_i,
    input wire logic seg_manchester_i,
    input wire logic [rcmb_pkg::STATUS_BITS-1:0] status_word_i,
    output logic seg_bit_req_o,
    output logic activity_seen_o,
    output logic multi_collision_seen_o,
    output logic cascade_rx_bit_o,
    output logic cascade_rx_strobe_o,
    output logic cascade_rx_frame_o,
    output logic cascade_rx_collision_o,
    output logic mgmt_bus_busy_o,
    output logic compress_active_o,
    // Cascade bus pins
    input wire logic cascade_serial_data_i,
    output logic cascade_serial_data_o,
    output logic cascade_serial_data_oe_o,
    input wire logic cascade_frame_enable_i,
    output logic cascade_frame_enable_o,
    output logic cascade_frame_enable_oe_o,
    input wire logic cascade_serial_clock_i,
    output logic cascade_serial_clock_o,
    output logic cascade_serial_clock_oe_o,
    input wire logic receive_port_collision_i,
    output logic receive_port_collision_o,
    output logic receive_port_collision_oe_o,
    output logic packet_bus_drive_enable_o,
    // Shared open-drain activity and collision lines
    output logic local_activity_drive_o,
    output logic local_activity_drive_oe_o,
    input wire logic activity_sense_i,
    output logic multi_collision_drive_o,
    output logic multi_collision_drive_oe_o,
    input wire logic multi_collision_sense_i,
    // Management bus pins
    output logic mgmt_rx_clock_o,
    output logic mgmt_rx_clock_oe_o,
    output logic mgmt_rx_serial_o,
    output logic mgmt_rx_serial_oe_o,
    input wire logic mgmt_carrier_sense_i,
    output logic mgmt_carrier_sense_o,
    output logic mgmt_carrier_sense_oe_o,
    output logic mgmt_drive_enable_o,
    input wire logic compress_request_n_i,
    // Test output
    output logic manchester_rx_monitor_o
);
    import rcmb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // True when two or more bits of the vector are set
    function automatic logic several_set(input logic [PORT_COUNT-1:0] v);
        logic seen;
        logic many;
        seen = 1'b0;
        many = 1'b0;
        for (int i = 0; i < PORT_COUNT; i++) begin
            if (v[i]) begin
                many = many | seen;
                seen = 1'b1;
            end
        end
        return many;
    endfunction

    // Open-drain lines read low when asserted
    function automatic logic od_active(input logic pin_level);
        return ~pin_level;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [SYNC_WIDTH-1:0] sync_meta;
    logic [SYNC_WIDTH-1:0] sync_pin;
    logic [SYNC_WIDTH-1:0] next_sync_meta;
    logic compress_meta;
    logic compress_n;
    logic next_compress_meta;

    // Gather raw pin levels
    always_comb begin
        next_sync_meta = {mgmt_carrier_sense_i, receive_port_collision_i, cascade_frame_enable_i,
                          cascade_serial_data_i, cascade_serial_clock_i, multi_collision_sense_i,
                          activity_sense_i};
        next_compress_meta = compress_request_n_i;
    end

    // Two flip-flops per pin
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sync_meta <= SYNC_RESET;
            sync_pin <= SYNC_RESET;
            compress_meta <= 1'b1;
            compress_n <= 1'b1;
        end else begin
            sync_meta <= next_sync_meta;
            sync_pin <= sync_meta;
            compress_meta <= next_compress_meta;
            compress_n <= compress_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serialiser state

    rcmb_state_type state;
    rcmb_state_type next_state;
    logic [DIV_WIDTH-1:0] div_cnt;
    logic [DIV_WIDTH-1:0] next_div_cnt;
    logic sclk;
    logic next_sclk;
    logic sdata;
    logic next_sdata;
    logic bit_req;
    logic next_bit_req;
    logic [BIT_CNT_WIDTH-1:0] bit_cnt;
    logic [BIT_CNT_WIDTH-1:0] next_bit_cnt;
    logic [STATUS_BITS-1:0] stat_sr;
    logic [STATUS_BITS-1:0] next_stat_sr;
    logic [STAT_CNT_WIDTH-1:0] stat_cnt;
    logic [STAT_CNT_WIDTH-1:0] next_stat_cnt;
    logic compress;
    logic next_compress;
    logic tick;
    logic fall;
    logic rise;

    // Bit clock divider, packet and status shifting
    always_comb begin
        next_state = state;
        next_div_cnt = div_cnt;
        next_sclk = sclk;
        next_sdata = sdata;
        next_bit_req = 1'b0;
        next_bit_cnt = bit_cnt;
        next_stat_sr = stat_sr;
        next_stat_cnt = stat_cnt;
        next_compress = compress;
        tick = (div_cnt == DIV_LAST);
        fall = tick & sclk;
        rise = tick & ~sclk;
        unique case (state)
            ST_IDLE: begin
                next_div_cnt = DIV_RESET;
                next_sclk = 1'b0;
                if (seg_rx_active_i) begin
                    next_state = ST_PACKET;
                    next_sdata = seg_rx_bit_i;
                    next_bit_req = 1'b1;
                    next_bit_cnt = BIT_CNT_FIRST;
                    next_compress = 1'b0;
                end
            end
            ST_PACKET: begin
                next_div_cnt = tick ? DIV_RESET : div_cnt + 8'h01;
                if (tick) begin
                    next_sclk = ~sclk;
                end
                // Low request compresses [R13] [R14]
                if (rise && !compress_n) begin
                    next_compress = 1'b1;
                end
                // New bits only at clock fall [R08] [R16]
                if (fall) begin
                    if (seg_rx_active_i) begin
                        next_sdata = seg_rx_bit_i;
                        next_bit_req = 1'b1;
                        if (bit_cnt != BIT_CNT_MAX) begin
                            next_bit_cnt = bit_cnt + BIT_CNT_FIRST;
                        end
                    end else begin
                        // Packet done, status follows [R11]
                        next_state = ST_STATUS;
                        next_stat_sr = status_word_i;
                        next_sdata = status_word_i[STATUS_BITS-1];
                        next_stat_cnt = STAT_CNT_FIRST;
                    end
                end
            end
            ST_STATUS: begin
                next_div_cnt = tick ? DIV_RESET : div_cnt + 8'h01;
                if (tick) begin
                    next_sclk = ~sclk;
                end
                if (fall) begin
                    if (stat_cnt == STAT_CNT_LAST) begin
                        next_state = ST_IDLE;
                        next_sclk = 1'b0;
                        next_div_cnt = DIV_RESET;
                    end else begin
                        next_stat_sr = {stat_sr[STATUS_BITS-2:0], 1'b0};
                        next_sdata = stat_sr[STATUS_BITS-2];
                        next_stat_cnt = stat_cnt + STAT_CNT_FIRST;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_sclk = 1'b0;
                next_div_cnt = DIV_RESET;
            end
        endcase
    end

    // Serialiser registers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            div_cnt <= DIV_RESET;
            sclk <= 1'b0;
            sdata <= 1'b0;
            bit_req <= 1'b0;
            bit_cnt <= BIT_CNT_RESET;
            stat_sr <= STATUS_RESET;
            stat_cnt <= STAT_CNT_RESET;
            compress <= 1'b0;
        end else begin
            state <= next_state;
            div_cnt <= next_div_cnt;
            sclk <= next_sclk;
            sdata <= next_sdata;
            bit_req <= next_bit_req;
            bit_cnt <= next_bit_cnt;
            stat_sr <= next_stat_sr;
            stat_cnt <= next_stat_cnt;
            compress <= next_compress;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cascade receive side

    logic cas_clk_prev;
    logic next_cas_clk_prev;
    logic cas_bit;
    logic next_cas_bit;
    logic cas_strobe;
    logic next_cas_strobe;

    // Sample cascade data on clock rise [R16] [R02]
    always_comb begin
        next_cas_clk_prev = sync_pin[SY_CAS_CLK];
        next_cas_bit = cas_bit;
        next_cas_strobe = 1'b0;
        if ((state == ST_IDLE) && sync_pin[SY_CAS_FRAME] && sync_pin[SY_CAS_CLK] && !cas_clk_prev) begin
            next_cas_bit = sync_pin[SY_CAS_DATA];
            next_cas_strobe = 1'b1;
        end
    end

    // Cascade receive registers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cas_clk_prev <= 1'b0;
            cas_bit <= 1'b0;
            cas_strobe <= 1'b0;
        end else begin
            cas_clk_prev <= next_cas_clk_prev;
            cas_bit <= next_cas_bit;
            cas_strobe <= next_cas_strobe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output registers

    logic drive_packet;
    logic drive_mgmt;
    logic hide_clock;
    logic next_local_act_oe;
    logic next_multi_col_oe;

    // Drive decisions
    always_comb begin
        drive_packet = (next_state == ST_PACKET);
        drive_mgmt = (next_state != ST_IDLE);
        // Compressed tail gets no management clock [R13]
        hide_clock = next_compress && drive_packet && (next_bit_cnt > COMPRESS_KEEP_BITS);
        next_local_act_oe = seg_rx_active_i | seg_rx_collision_i; // [R04]
        next_multi_col_oe = tx_collision_i | several_set(port_collision_i); // [R06]
    end

    // Output flip-flops
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            packet_bus_drive_enable_o <= 1'b0;
            cascade_serial_data_o <= 1'b0;
            cascade_serial_data_oe_o <= 1'b0;
            cascade_frame_enable_o <= 1'b0;
            cascade_frame_enable_oe_o <= 1'b0;
            cascade_serial_clock_o <= 1'b0;
            cascade_serial_clock_oe_o <= 1'b0;
            receive_port_collision_o <= 1'b0;
            receive_port_collision_oe_o <= 1'b0;
            local_activity_drive_o <= 1'b0;
            local_activity_drive_oe_o <= 1'b0;
            multi_collision_drive_o <= 1'b0;
            multi_collision_drive_oe_o <= 1'b0;
            mgmt_rx_clock_o <= 1'b0;
            mgmt_rx_clock_oe_o <= 1'b0;
            mgmt_rx_serial_o <= 1'b0;
            mgmt_rx_serial_oe_o <= 1'b0;
            mgmt_carrier_sense_o <= 1'b0;
            mgmt_carrier_sense_oe_o <= 1'b0;
            mgmt_drive_enable_o <= 1'b0;
            manchester_rx_monitor_o <= 1'b0;
            seg_bit_req_o <= 1'b0;
            activity_seen_o <= 1'b0;
            multi_collision_seen_o <= 1'b0;
            cascade_rx_bit_o <= 1'b0;
            cascade_rx_strobe_o <= 1'b0;
            cascade_rx_frame_o <= 1'b0;
            cascade_rx_collision_o <= 1'b0;
            mgmt_bus_busy_o <= 1'b0;
            compress_active_o <= 1'b0;
        end else begin
            // Cascade bus
            packet_bus_drive_enable_o <= drive_packet; // [R01] [R02]
            cascade_serial_data_o <= next_sdata; // [R16]
            cascade_serial_data_oe_o <= drive_packet; // [R01]
            cascade_frame_enable_o <= drive_packet;
            cascade_frame_enable_oe_o <= drive_packet; // [R01]
            cascade_serial_clock_o <= drive_packet & next_sclk;
            cascade_serial_clock_oe_o <= drive_packet; // [R01]
            receive_port_collision_o <= seg_rx_collision_i;
            receive_port_collision_oe_o <= drive_packet; // [R01]
            // Open-drain lines pull low when enabled
            local_activity_drive_oe_o <= next_local_act_oe; // [R04]
            multi_collision_drive_oe_o <= next_multi_col_oe; // [R06]
            // Management bus
            mgmt_rx_clock_o <= drive_mgmt & next_sclk & ~hide_clock; // [R09] [R13]
            mgmt_rx_clock_oe_o <= drive_mgmt; // [R17]
            mgmt_rx_serial_o <= drive_mgmt & next_sdata; // [R08] [R11]
            mgmt_rx_serial_oe_o <= drive_mgmt; // [R17]
            mgmt_carrier_sense_o <= drive_mgmt;
            mgmt_carrier_sense_oe_o <= drive_mgmt; // [R10]
            mgmt_drive_enable_o <= drive_mgmt; // [R12]
            // Test copy of the receiving port's Manchester stream
            manchester_rx_monitor_o <= seg_manchester_i; // [R15]
            // Core side status
            seg_bit_req_o <= next_bit_req;
            activity_seen_o <= od_active(sync_pin[SY_ACT_SENSE]); // [R05]
            multi_collision_seen_o <= od_active(sync_pin[SY_MCOL_SENSE]); // [R07]
            cascade_rx_bit_o <= next_cas_bit;
            cascade_rx_strobe_o <= next_cas_strobe;
            cascade_rx_frame_o <= (state == ST_IDLE) & sync_pin[SY_CAS_FRAME];
            cascade_rx_collision_o <= (state == ST_IDLE) & sync_pin[SY_CAS_COL];
            mgmt_bus_busy_o <= (state == ST_IDLE) & sync_pin[SY_MGMT_CRS]; // [R10]
            compress_active_o <= next_compress & drive_mgmt;
        end
    end

endmodule

/* File: shared/rcmb_pkg.sv */
package rcmb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and serial timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SERIAL_BIT_NS = 100;
    // Half bit period in system cycles, rounded down, never below one
    localparam int SERIAL_HALF_CYCLES_RAW = (SERIAL_BIT_NS * 1000) / (2 * CLK_PERIOD_PS);
    localparam int SERIAL_HALF_CYCLES = (SERIAL_HALF_CYCLES_RAW < 1) ? 1 : SERIAL_HALF_CYCLES_RAW;
    localparam int DIV_WIDTH = 8;
    localparam logic [DIV_WIDTH-1:0] DIV_LAST = 8'(SERIAL_HALF_CYCLES - 1);
    localparam logic [DIV_WIDTH-1:0] DIV_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Stream layout
    localparam int PORT_COUNT = 13;
    localparam int STATUS_BITS = 16;
    localparam int BIT_CNT_WIDTH = 16;
    localparam logic [BIT_CNT_WIDTH-1:0] BIT_CNT_MAX = 16'hFFFF;
    localparam logic [BIT_CNT_WIDTH-1:0] BIT_CNT_RESET = 16'h0000;
    localparam logic [BIT_CNT_WIDTH-1:0] BIT_CNT_FIRST = 16'h0001;
    // Packet bits still shown on the management bus once compression is asked
    localparam logic [BIT_CNT_WIDTH-1:0] COMPRESS_KEEP_BITS = 16'h0200;
    localparam int STAT_CNT_WIDTH = 5;
    localparam logic [STAT_CNT_WIDTH-1:0] STAT_CNT_LAST = 5'h10;
    localparam logic [STAT_CNT_WIDTH-1:0] STAT_CNT_RESET = 5'h00;
    localparam logic [STAT_CNT_WIDTH-1:0] STAT_CNT_FIRST = 5'h01;
    localparam logic [STATUS_BITS-1:0] STATUS_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Synchroniser bit positions for pin inputs
    localparam int SYNC_WIDTH = 7;
    localparam int SY_ACT_SENSE = 0;
    localparam int SY_MCOL_SENSE = 1;
    localparam int SY_CAS_CLK = 2;
    localparam int SY_CAS_DATA = 3;
    localparam int SY_CAS_FRAME = 4;
    localparam int SY_CAS_COL = 5;
    localparam int SY_MGMT_CRS = 6;
    localparam int SY_COMPRESS_N = 6;
    localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 7'h03;

    ////////////////////////////////////////////////////////////////////////////
    // Serialiser states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_PACKET = 3'b010,
        ST_STATUS = 3'b100
    } rcmb_state_type;

endpackage
